//--- hw/pin_change_irq.sv
/*
  Pin-change interrupt controller with top-level interrupt gating.
  Assumes a single-cycle register port from the core, raw asynchronous
  port pins, and a core that reports when it is asleep.
*/
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pin_change_irq
  import pin_change_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire pin_change_pkg::port_bits_t portPins [pin_change_pkg::NUM_PORTS],
  input  wire logic                       extIrqPin,
  input  wire logic                       sleeping,
  input  wire logic [5:0]                 addr,
  input  wire logic [7:0]                 wrData,
  input  wire logic                       wrStrobe,
  input  wire logic                       rdStrobe,
  output logic      [7:0]                 rdData,
  output logic                            irqOut,
  output logic                            wakeOut
);

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  pin_sync_if sync ();

  pin_sampler u_sampler (
    .clk       (clk),
    .resetn    (resetn),
    .portPins  (portPins),
    .extIrqPin (extIrqPin),
    .sync      (sync)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic portHit(input logic [5:0] a, input int p, input logic [1:0] sub);
    portHit = (a == ADDR_PORT_BASE + 6'(p * 4) + 6'(sub));
  endfunction

  wire wrIntCtrl  = wrStrobe && (addr == ADDR_INT_CTRL);
  wire wrIrqEn    = wrStrobe && (addr == ADDR_IRQ_ENABLE);
  wire wrExtClear = wrStrobe && (addr == ADDR_EXT_CLEAR);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic       globalIrqEnable_reg;
  logic       periphIrqEnable_reg;
  logic       extPinEdgeSelect_reg;
  logic       changeIrqEnable_reg;
  logic       extIrqEnable_reg;
  logic       extIrqFlag_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      globalIrqEnable_reg  <= INT_CTRL_RESET[GIE_BIT];
      periphIrqEnable_reg  <= INT_CTRL_RESET[PERIPHERAL_IRQ_ENABLE_BIT];
      extPinEdgeSelect_reg <= INT_CTRL_RESET[EDGE_BIT];
    end
    else if (wrIntCtrl)
    begin
      globalIrqEnable_reg  <= wrData[GIE_BIT];
      periphIrqEnable_reg  <= wrData[PERIPHERAL_IRQ_ENABLE_BIT];
      extPinEdgeSelect_reg <= wrData[EDGE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      changeIrqEnable_reg <= 1'b0;
      extIrqEnable_reg    <= 1'b0;
    end
    else if (wrIrqEn)
    begin
      changeIrqEnable_reg <= wrData[CHG_IE_BIT];
      extIrqEnable_reg    <= wrData[EXT_IE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // External interrupt pin
  // ----------------------------------------------------------------
  wire extRise = sync.extNow && !sync.extPrev;
  wire extFall = !sync.extNow && sync.extPrev;
  wire extEdge = extPinEdgeSelect_reg ? extRise : extFall;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      extIrqFlag_reg <= 1'b0;
    else if (extEdge)
      extIrqFlag_reg <= 1'b1;
    else if (wrExtClear && wrData[EXT_IF_BIT])
      extIrqFlag_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Per-port edge detection and flags
  // ----------------------------------------------------------------
  port_bits_t riseEnable_reg [NUM_PORTS];
  port_bits_t fallEnable_reg [NUM_PORTS];
  port_bits_t pinFlag_reg    [NUM_PORTS];
  port_bits_t pinFlag_next   [NUM_PORTS];
  port_bits_t edgeHit        [NUM_PORTS];
  logic [NUM_PORTS-1:0] portAny;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      // The fourth port has no change logic on the large variant
      localparam bit PORT_USED = !(LARGE_VARIANT && (p == FOURTH_PORT));

      wire wrRise = wrStrobe && portHit(addr, p, SUB_RISE);
      wire wrFall = wrStrobe && portHit(addr, p, SUB_FALL);
      wire wrFlag = wrStrobe && portHit(addr, p, SUB_FLAG);

      wire port_bits_t rising  = sync.pinNow[p] & ~sync.pinPrev[p];
      wire port_bits_t falling = ~sync.pinNow[p] & sync.pinPrev[p];

      // Independent detectors, either or both may be armed
      assign edgeHit[p] = PORT_USED ?
        ((rising & riseEnable_reg[p]) | (falling & fallEnable_reg[p])) :
        ZERO_BYTE;

      // Zero bits in the written value clear flags; a fresh edge always lands set
      assign pinFlag_next[p] = (wrFlag ? (pinFlag_reg[p] & wrData) : pinFlag_reg[p])
                               | edgeHit[p];

      assign portAny[p] = |pinFlag_reg[p];

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          riseEnable_reg[p] <= ZERO_BYTE;
          fallEnable_reg[p] <= ZERO_BYTE;
        end
        else
        begin
          if (wrRise && PORT_USED)
            riseEnable_reg[p] <= wrData;
          if (wrFall && PORT_USED)
            fallEnable_reg[p] <= wrData;
        end
      end

      // Flags run from the system clock whether or not the core sleeps
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          pinFlag_reg[p] <= ZERO_BYTE;
        else
          pinFlag_reg[p] <= pinFlag_next[p];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Summary, gating and wake
  // ----------------------------------------------------------------
  wire changeSummary = |portAny;

  wire changeRequest = changeSummary && changeIrqEnable_reg;
  wire extRequest    = extIrqFlag_reg && extIrqEnable_reg;

  // The change interrupt is a peripheral source; the external pin is not
  wire periphGate = periphIrqEnable_reg && changeRequest;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqOut  <= 1'b0;
      wakeOut <= 1'b0;
    end
    else
    begin
      irqOut  <= globalIrqEnable_reg && (periphGate || extRequest);
      wakeOut <= sleeping && (changeRequest || extRequest);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] readMux;

  always_comb
  begin
    readMux = ZERO_BYTE;
    unique case (addr)
      ADDR_INT_CTRL:
        readMux = {globalIrqEnable_reg, periphIrqEnable_reg, 5'h00, extPinEdgeSelect_reg};
      ADDR_IRQ_ENABLE:
        readMux = {3'h0, changeIrqEnable_reg, 3'h0, extIrqEnable_reg};
      ADDR_IRQ_REQ, ADDR_EXT_STATUS:
        readMux = {3'h0, changeSummary, 3'h0, extIrqFlag_reg};
      default:
      begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
          if (portHit(addr, i, SUB_RISE))
            readMux = riseEnable_reg[i];
          if (portHit(addr, i, SUB_FALL))
            readMux = fallEnable_reg[i];
          if (portHit(addr, i, SUB_FLAG))
            readMux = pinFlag_reg[i];
          if (portHit(addr, i, SUB_PINS))
            readMux = sync.pinNow[i];
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdData <= ZERO_BYTE;
    else if (rdStrobe)
      rdData <= readMux;
    else
      rdData <= ZERO_BYTE;
  end

endmodule

`default_nettype wire

//--- hw/pin_change_pkg.sv
/*
  Constants, register map and types for the pin-change interrupt controller.
  Assumes a plain single-cycle register port and one 40 MHz system clock.
*/
package pin_change_pkg;

  localparam int NUM_PORTS  = 5;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 6;
  localparam int DATA_WIDTH = 8;

  // Index of the port that cannot take part on the large package variant
  localparam int FOURTH_PORT = 3;

  // Register indices; ports occupy blocks of four
  localparam logic [5:0] ADDR_INT_CTRL   = 6'h00;
  localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h01;
  localparam logic [5:0] ADDR_IRQ_REQ    = 6'h02;
  localparam logic [5:0] ADDR_EXT_STATUS = 6'h03;
  localparam logic [5:0] ADDR_EXT_CLEAR  = 6'h04;
  localparam logic [5:0] ADDR_PORT_BASE  = 6'h08;
  localparam logic [1:0] SUB_RISE        = 2'h0;
  localparam logic [1:0] SUB_FALL        = 2'h1;
  localparam logic [1:0] SUB_FLAG        = 2'h2;
  localparam logic [1:0] SUB_PINS        = 2'h3;

  // Field positions
  localparam int GIE_BIT    = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT   = 6;
  localparam int EDGE_BIT   = 0;
  localparam int CHG_IE_BIT = 4;
  localparam int EXT_IE_BIT = 0;
  localparam int CHG_IF_BIT = 4;
  localparam int EXT_IF_BIT = 0;

  // Reset values
  localparam logic [7:0] INT_CTRL_RESET = 8'h01;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  typedef logic [PORT_WIDTH-1:0] port_bits_t;

endpackage

//--- hw/pin_sync_if.sv
/*
  Interface carrying the synchronised pin samples between the sampler and
  the controller. Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if;
  import pin_change_pkg::*;

  port_bits_t pinNow  [NUM_PORTS];
  port_bits_t pinPrev [NUM_PORTS];
  logic       extNow;
  logic       extPrev;

  modport source (output pinNow, output pinPrev, output extNow, output extPrev);
  modport sink   (input pinNow, input pinPrev, input extNow, input extPrev);
endinterface

`default_nettype wire

//--- hw/pin_sampler.sv
/*
  Two-flop synchroniser plus one history stage for every port pin and the
  external interrupt pin. Assumes raw pins are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sampler
  import pin_change_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire pin_change_pkg::port_bits_t portPins [pin_change_pkg::NUM_PORTS],
  input  wire logic                     extIrqPin,
  pin_sync_if.source                    sync
);

  port_bits_t meta_reg  [NUM_PORTS];
  port_bits_t now_reg   [NUM_PORTS];
  port_bits_t prev_reg  [NUM_PORTS];
  logic [2:0] ext_reg;
  logic [2:0] warm_reg;

  // History is trusted only after three samples, so a pin that is high
  // at reset release is not seen as an edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      warm_reg <= 3'h0;
    else
      warm_reg <= {warm_reg[1:0], 1'b1};
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_reg[p] <= ZERO_BYTE;
          now_reg[p]  <= ZERO_BYTE;
          prev_reg[p] <= ZERO_BYTE;
        end
        else
        begin
          meta_reg[p] <= portPins[p];
          now_reg[p]  <= meta_reg[p];
          prev_reg[p] <= now_reg[p];
        end
      end
      assign sync.pinNow[p]  = now_reg[p];
      assign sync.pinPrev[p] = warm_reg[2] ? prev_reg[p] : now_reg[p];
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ext_reg <= 3'h0;
    else
      ext_reg <= {ext_reg[1:0], extIrqPin};
  end

  assign sync.extNow  = ext_reg[1];
  assign sync.extPrev = warm_reg[2] ? ext_reg[2] : ext_reg[1];

endmodule

`default_nettype wire

//--- dv/pin_partner.sv
/*
  Behavioural model of the port pins and the external interrupt pin.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_partner
  import pin_change_pkg::*;
(
  output var pin_change_pkg::port_bits_t portPins [pin_change_pkg::NUM_PORTS],
  output var logic                       extIrqPin
);
  initial
  begin
    portPins  = '{default: '0};
    extIrqPin = 1'b0;
  end

  task automatic setPort(input int p, input port_bits_t v);
    portPins[p] <= v;
  endtask

  task automatic setExt(input logic v);
    extIrqPin <= v;
  endtask
endmodule

`default_nettype wire

//--- dv/pin_change_irq_props.sv
/*
  Port-level assertions for the pin-change controller.
  Assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_change_irq_props
  import pin_change_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire pin_change_pkg::port_bits_t portPins [pin_change_pkg::NUM_PORTS],
  input wire logic                       extIrqPin,
  input wire logic                       sleeping,
  input wire logic [5:0]                 addr,
  input wire logic [7:0]                 wrData,
  input wire logic                       wrStrobe,
  input wire logic                       rdStrobe,
  input wire logic [7:0]                 rdData,
  input wire logic                       irqOut,
  input wire logic                       wakeOut
);
  wire logic [40:0] inFlat = {>>{portPins, extIrqPin}};
  logic      [40:0] inLast;
  logic      [3:0]  quietCnt;
  logic      [3:0]  enSh;
  wire logic        quiet = quietCnt[3];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Counts cycles with no pin change and no write, saturating at 8
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      inLast   <= '0;
      quietCnt <= 4'h0;
    end
    else
    begin
      inLast   <= inFlat;
      quietCnt <= (wrStrobe || inFlat != inLast) ? 4'h0 : quietCnt + {3'h0, !quiet};
    end

  // Shadow of global, peripheral, change and external enables
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      enSh <= 4'h0;
    else if (wrStrobe && addr == ADDR_INT_CTRL)
      enSh[3:2] <= wrData[7:6];
    else if (wrStrobe && addr == ADDR_IRQ_ENABLE)
      enSh[1:0] <= {wrData[4], wrData[0]};

  AST_GLOBAL: assert property (irqOut |-> $past(enSh[3]))
    else $error("irq without global enable");
  AST_PERIPH: assert property (irqOut |-> $past(enSh[0] || (enSh[2] && enSh[1])))
    else $error("irq without source enable");
  AST_STICKY: assert property (irqOut && !wrStrobe && !$past(wrStrobe) |=> irqOut)
    else $error("irq dropped without a write");
  AST_QUIET: assert property (quiet && !irqOut |=> !irqOut)
    else $error("irq rose with quiet inputs");
  AST_PINS: assert property (rdStrobe && addr == 6'h0b && quiet |=> rdData == $past(inFlat[40:33]))
    else $error("synced pin read wrong");
  AST_RSVD: assert property (rdStrobe && addr == ADDR_INT_CTRL |=> rdData[5:1] == 5'h00)
    else $error("control unused bits not zero");
  AST_WAKE: assert property (wakeOut |-> $past(sleeping))
    else $error("wake while awake");
  AST_WAKE_EN: assert property (wakeOut |-> $past(enSh[1] || enSh[0]))
    else $error("wake without enable");
endmodule

bind pin_change_irq pin_change_irq_props PROPS (.clk(clk), .resetn(resetn),
  .portPins(portPins), .extIrqPin(extIrqPin), .sleeping(sleeping), .addr(addr),
  .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .irqOut(irqOut), .wakeOut(wakeOut));

`default_nettype wire

//--- dv/pin_change_irq_bench.sv
/*
  Self-checking bench for the pin-change controller.
  Assumes the pin partner model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_change_irq_bench;
  import pin_change_pkg::*;
  logic       clk      = 1'b0;
  logic       resetn   = 1'b0;
  logic       sleeping = 1'b0;
  logic [5:0] addr     = 6'h00;
  logic [7:0] wrData   = 8'h00;
  logic       wrStrobe = 1'b0;
  logic       rdStrobe = 1'b0;
  logic [7:0] rdData;
  logic [7:0] rdDataL;
  logic       irqOut;
  logic       wakeOut;
  logic       extIrqPin;
  port_bits_t portPins [NUM_PORTS];
  int         errors     = 0;
  int         n_compared = 0;

  initial forever #12.5 clk = ~clk;

  pin_partner P (.portPins(portPins), .extIrqPin(extIrqPin));
  pin_change_irq DUT (.clk(clk), .resetn(resetn), .portPins(portPins),
    .extIrqPin(extIrqPin), .sleeping(sleeping), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .irqOut(irqOut),
    .wakeOut(wakeOut));
  pin_change_irq #(.LARGE_VARIANT(1'b1)) DUT_LARGE (.clk(clk), .resetn(resetn),
    .portPins(portPins), .extIrqPin(extIrqPin), .sleeping(sleeping), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdDataL),
    .irqOut(), .wakeOut());

  task automatic print_verdict();
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask

  task automatic rd(input string n, input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    chk(n, e, rdData);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [5:0] pa(input int p, input logic [1:0] s);
    return ADDR_PORT_BASE + 6'(4 * p) + {4'h0, s};
  endfunction

  task automatic t_reset();
    rd("ctrl", ADDR_INT_CTRL, 8'h01);
    rd("status", ADDR_IRQ_REQ, 8'h00);
    rd("enable", ADDR_IRQ_ENABLE, 8'h00);
    rd("unmapped", 6'h3f, 8'h00);
  endtask

  // Pin 0 rise only, pin 1 fall only, pin 2 both, on every port
  task automatic t_edges();
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      wr(pa(p, SUB_RISE), 8'h05);
      wr(pa(p, SUB_FALL), 8'h06);
      P.setPort(p, 8'h07);
      idle(8);
      rd("pins", pa(p, SUB_PINS), 8'h07);
      rd("flag rise", pa(p, SUB_FLAG), 8'h05);
      P.setPort(p, 8'h00);
      idle(8);
      rd("flag both", pa(p, SUB_FLAG), 8'h07);
      wr(pa(p, SUB_FLAG), 8'hfe);
      rd("flag mask", pa(p, SUB_FLAG), 8'h06);
      wr(pa(p, SUB_FLAG), 8'h00);
      rd("flag clear", pa(p, SUB_FLAG), 8'h00);
    end
  endtask

  // Port 3 change logic is absent on the large variant
  task automatic t_large();
    wr(pa(3, SUB_RISE), 8'hff);
    P.setPort(3, 8'hff);
    idle(8);
    rd("port3 flag", pa(3, SUB_FLAG), 8'hff);
    chk("large flag", 8'h00, rdDataL);
    rd("port3 rise", pa(3, SUB_RISE), 8'hff);
    chk("large rise", 8'h00, rdDataL);
    P.setPort(3, 8'h00);
    idle(8);
    wr(pa(3, SUB_RISE), 8'h00);
    wr(pa(3, SUB_FLAG), 8'h00);
    rd("port3 clear", pa(3, SUB_FLAG), 8'h00);
  endtask

  task automatic t_gate();
    wr(ADDR_INT_CTRL, 8'hc1);
    P.setPort(4, 8'h01);
    idle(8);
    rd("summary", ADDR_IRQ_REQ, 8'h10);
    chk("irq no change enable", 8'h00, {7'h00, irqOut});
    wr(ADDR_IRQ_ENABLE, 8'h10);
    idle(3);
    chk("irq on", 8'h01, {7'h00, irqOut});
    wr(ADDR_INT_CTRL, 8'h41);
    idle(3);
    chk("irq no global", 8'h00, {7'h00, irqOut});
    wr(ADDR_INT_CTRL, 8'h81);
    idle(3);
    chk("irq no periph", 8'h00, {7'h00, irqOut});
    wr(ADDR_IRQ_REQ, 8'h00);
    rd("summary ro", ADDR_IRQ_REQ, 8'h10);
    wr(pa(4, SUB_FLAG), 8'h00);
    rd("summary clear", ADDR_IRQ_REQ, 8'h00);
    P.setPort(4, 8'h00);
  endtask

  // A clearing write on the edge that sets the flag leaves it set
  task automatic t_race();
    for (int k = 2; k <= 4; k += 2)
    begin
      @(posedge clk);
      P.setPort(0, 8'h01);
      repeat (k - 1) @(posedge clk);
      wr(pa(0, SUB_FLAG), 8'h00);
      idle(6);
      rd("flag race", pa(0, SUB_FLAG), (k == 2) ? 8'h01 : 8'h00);
      P.setPort(0, 8'h00);
      idle(6);
      wr(pa(0, SUB_FLAG), 8'h00);
    end
  endtask

  task automatic t_ext();
    wr(ADDR_IRQ_ENABLE, 8'h01);
    for (int s = 1; s >= 0; s--)
    begin
      wr(ADDR_INT_CTRL, {7'h40, s[0]});
      P.setExt(1'b1);
      idle(6);
      rd("ext rise", ADDR_IRQ_REQ, {7'h00, s[0]});
      chk("ext irq", {7'h00, s[0]}, {7'h00, irqOut});
      wr(ADDR_EXT_CLEAR, 8'h01);
      P.setExt(1'b0);
      idle(6);
      rd("ext fall", ADDR_IRQ_REQ, {7'h00, ~s[0]});
      wr(ADDR_EXT_CLEAR, 8'h01);
    end
  endtask

  task automatic t_wake();
    int i;
    wr(ADDR_IRQ_ENABLE, 8'h10);
    wr(ADDR_INT_CTRL, 8'h01);
    sleeping <= 1'b1;
    P.setPort(2, 8'h01);
    for (i = 0; i < 12 && wakeOut !== 1'b1; i++)
      idle(1);
    chk("wake", 8'h01, {7'h00, wakeOut});
    if (wakeOut !== 1'b1)
      print_verdict();
    else
    begin
      rd("wake flag", pa(2, SUB_FLAG), 8'h01);
      @(posedge clk);
      sleeping <= 1'b0;
      idle(2);
      chk("awake", 8'h00, {7'h00, wakeOut});
    end
  endtask

  initial
  begin
    #(25 * 100000);
    errors++;
    print_verdict();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_edges();
    t_large();
    t_gate();
    t_race();
    t_ext();
    t_wake();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset outputs", 8'h00, {6'h00, irqOut, wakeOut});
    resetn <= 1'b1;
    t_reset();
    print_verdict();
  end
endmodule

`default_nettype wire
